// ---- verilog/tpi_pkg.sv ----
// Package for the image datapath test pattern inserter.
// Assumes a 16-bit configuration port with word addresses and 10-bit lanes.
`default_nettype none

package tpi_pkg;

    // Widths of the configuration port and of the datapaths
    localparam int unsigned ADDR_W  = 9;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned LANES   = 4;
    localparam int unsigned WORD_W  = 10;
    localparam int unsigned NARROW_W = 8;

    // Register addresses
    localparam logic [8:0] ADDR_RESERVED_STATUS_A  = 9'h08a;
    localparam logic [8:0] ADDR_RESERVED_STATUS_B  = 9'h08b;
    localparam logic [8:0] ADDR_RESERVED_SETTING_A = 9'h08c;
    localparam logic [8:0] ADDR_RESERVED_SETTING_B = 9'h08d;
    localparam logic [8:0] ADDR_PATTERN_MODE       = 9'h090;
    localparam logic [8:0] ADDR_RESERVED_SETTING_C = 9'h091;
    localparam logic [8:0] ADDR_LANE01_LOW         = 9'h092;
    localparam logic [8:0] ADDR_LANE23_LOW         = 9'h093;
    localparam logic [8:0] ADDR_RESERVED_SETTING_D = 9'h094;
    localparam logic [8:0] ADDR_SPARE_LOW          = 9'h095;
    localparam logic [8:0] ADDR_LANE_HIGH          = 9'h096;

    // Reset values
    localparam logic [15:0] RST_RESERVED_SETTING_A = 16'h0000;
    localparam logic [15:0] RST_RESERVED_SETTING_B = 16'hffff;
    localparam logic [15:0] RST_PATTERN_MODE       = 16'h0000;
    localparam logic [15:0] RST_RESERVED_SETTING_C = 16'h0000;
    localparam logic [15:0] RST_LANE01_LOW         = 16'h0100;
    localparam logic [15:0] RST_LANE23_LOW         = 16'h0302;
    localparam logic [15:0] RST_RESERVED_SETTING_D = 16'h0504;
    localparam logic [15:0] RST_SPARE_LOW          = 16'h0706;
    localparam logic [15:0] RST_LANE_HIGH          = 16'h0000;

    // Field positions in pattern_mode_control
    localparam int unsigned BIT_INSERT_EN = 0;
    localparam int unsigned BIT_RAMP_SEL  = 1;
    localparam int unsigned BIT_PRBS_EN   = 2;
    localparam int unsigned BIT_FRAMED    = 3;
    localparam logic [15:0] MODE_MASK     = 16'h000f;

    // Field layout of the low and high pattern registers
    localparam int unsigned LOW_FIELD_W  = 8;
    localparam int unsigned HIGH_FIELD_W = 2;
    localparam logic [15:0] HIGH_MASK    = 16'h00ff;

    // Pseudo-random generator shape
    localparam int unsigned PRBS_W       = 15;
    localparam logic [14:0] PRBS_SEED    = 15'h7fff;

endpackage

`default_nettype wire

// ---- verilog/tpi_prbs_if.sv ----
// Carrier between the inserter core and its pseudo-random generator.
// Both ends run on the same clock; no crossing is involved.
`default_nettype none

interface tpi_prbs_if;
    import tpi_pkg::*;
    logic                restart;  // Reload the seed
    logic                advance;  // Step once per output word
    logic [PRBS_W-1:0]   state;    // Current shift register contents

    modport gen  (input restart, input advance, output state);
    modport user (output restart, output advance, input state);
endinterface

`default_nettype wire

// ---- verilog/tpi_prbs.sv ----
// Pseudo-random sequence generator, one step per output word.
// Assumes a synchronous active-high reset from the top module.
`default_nettype none

module tpi_prbs
    import tpi_pkg::*;
#(
    parameter logic [14:0] SEED = PRBS_SEED
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Generator side of the carrier
    tpi_prbs_if.gen   prbs
);

    typedef struct packed {
        logic [PRBS_W-1:0] lfsr;  // Shift register
    } tpi_prbs_s;

    tpi_prbs_s cur;      // Registered state
    tpi_prbs_s next_cur; // Next state

    // Taps at x^15 + x^14 + 1; the all-zero lock-up state is never seeded
    always_comb begin
        next_cur = cur;
        if (prbs.restart) begin
            next_cur.lfsr = SEED;
        end else if (prbs.advance) begin
            next_cur.lfsr = {cur.lfsr[PRBS_W-2:0],
                             cur.lfsr[PRBS_W-1] ^ cur.lfsr[PRBS_W-2]};
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            cur.lfsr <= SEED;
        end else begin
            cur <= next_cur;
        end
    end

    assign prbs.state = cur.lfsr;

endmodule

`default_nettype wire

// ---- verilog/tpi_inserter.sv ----
// Test pattern inserter for four image output datapaths.
// Assumes pixel inputs and the configuration port share the clock.
//
// Functional notes
// - Enable bit replaces pixels with test pattern
// - Ramp bit: increment, else fixed per-lane value
// - PRBS bit drives pseudo-random data instead
// - Framed bit keeps sync framing, else continuous
// - Lane0/lane1 low bytes, reset 0x00 and 0x01
// - Lane2/lane3 low bytes, reset 0x02 and 0x03
// - High bits: two-bit fields from bit zero
`default_nettype none

module tpi_inserter
    import tpi_pkg::*;
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     resetn,
    // Configuration port, word addressed
    input  wire logic [tpi_pkg::ADDR_W-1:0] cfg_addr,
    input  wire logic [tpi_pkg::DATA_W-1:0] cfg_wdata,
    input  wire logic                     cfg_write,
    input  wire logic                     cfg_read,
    output logic [tpi_pkg::DATA_W-1:0]    cfg_rdata,
    output logic                          cfg_rvalid,
    // Pixel stream from the sensor datapath
    input  wire logic [tpi_pkg::LANES*tpi_pkg::WORD_W-1:0] in_data,
    input  wire logic                     in_valid,
    input  wire logic                     in_frame_start,
    input  wire logic                     in_line_start,
    input  wire logic                     narrow_mode,
    // Stream towards the output serialisers
    output logic [tpi_pkg::LANES*tpi_pkg::WORD_W-1:0] out_data,
    output logic                          out_valid,
    output logic                          out_frame_start,
    output logic                          out_line_start
);

    typedef struct packed {
        logic [DATA_W-1:0] rsv_a;        // reserved_setting_a
        logic [DATA_W-1:0] rsv_b;        // reserved_setting_b
        logic [DATA_W-1:0] mode;         // pattern_mode_control
        logic [DATA_W-1:0] rsv_c;        // reserved_setting_c
        logic [DATA_W-1:0] lane01_low;   // lane01_pattern_low
        logic [DATA_W-1:0] lane23_low;   // lane23_pattern_low
        logic [DATA_W-1:0] rsv_d;        // reserved_setting_d
        logic [DATA_W-1:0] spare_low;    // spare_pattern_low
        logic [DATA_W-1:0] high_bits;    // lane_pattern_high_bits
        logic [LANES*WORD_W-1:0] ramp;   // Per-lane ramp values
        logic [DATA_W-1:0] rdata;        // Read answer
        logic              rvalid;       // Read answer strobe
        logic [LANES*WORD_W-1:0] odata;  // Output words
        logic              ovalid;       // Output valid
        logic              ofs;          // Output frame start
        logic              ols;          // Output line start
    } tpi_inserter_s;

    tpi_inserter_s cur;       // Registered state
    tpi_inserter_s next_cur;  // Next state
    logic [1:0]    rst_pipe;  // Reset release synchroniser
    logic          rst;       // Synchronised active-high reset

    tpi_prbs_if prbs_link (); // Link to the generator

    // Programmed value of one lane: high field above low byte
    function automatic logic [WORD_W-1:0] lane_value(
        input logic [DATA_W-1:0] lo01,
        input logic [DATA_W-1:0] lo23,
        input logic [DATA_W-1:0] hi,
        input int unsigned       lane
    );
        logic [LOW_FIELD_W-1:0]  lo;
        logic [HIGH_FIELD_W-1:0] hb;
        lo = 8'h00;
        hb = 2'h0;
        case (lane)
            0: lo = lo01[7:0];
            1: lo = lo01[15:8];
            2: lo = lo23[7:0];
            default: lo = lo23[15:8];
        endcase
        hb = hi[lane*HIGH_FIELD_W +: HIGH_FIELD_W];
        return {hb, lo};
    endfunction

    // Clip a word to the active width
    function automatic logic [WORD_W-1:0] clip(
        input logic [WORD_W-1:0] w,
        input logic              narrow
    );
        return narrow ? {2'h0, w[NARROW_W-1:0]} : w;
    endfunction

    // Reset is applied at once and released through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h3;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b0};
        end
    end
    assign rst = rst_pipe[1];

    // Pseudo-random generator
    tpi_prbs #(
        .SEED (PRBS_SEED)
    ) u_prbs (
        .clock (clock),
        .rst   (rst),
        .prbs  (prbs_link.gen)
    );

    // Mode decode
    logic insert_en;  // Fixed or ramp pattern selected
    logic ramp_sel;   // Incrementing pattern
    logic prbs_en;    // Pseudo-random pattern selected
    logic framed;     // Keep sync framing
    logic any_test;   // Some test source replaces pixels
    logic word_step;  // An output word is produced this cycle
    assign insert_en = cur.mode[BIT_INSERT_EN];
    assign ramp_sel  = cur.mode[BIT_RAMP_SEL];
    assign prbs_en   = cur.mode[BIT_PRBS_EN];
    assign framed    = cur.mode[BIT_FRAMED];
    assign any_test  = insert_en | prbs_en;
    // Unframed test data streams every cycle; framed follows pixel valid
    assign word_step = any_test & (framed ? in_valid : 1'b1);

    // Generator steps once per word and restarts while idle
    assign prbs_link.restart = ~prbs_en;
    assign prbs_link.advance = prbs_en & word_step;

    // Next-state logic: register writes, reads, pattern and output
    always_comb begin
        next_cur        = cur;
        next_cur.rvalid = 1'b0;

        // Register writes; reserved bits are not stored
        if (cfg_write) begin
            if (cfg_addr == ADDR_RESERVED_SETTING_A) begin
                next_cur.rsv_a = cfg_wdata;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_B) begin
                next_cur.rsv_b = cfg_wdata;
            end else if (cfg_addr == ADDR_PATTERN_MODE) begin
                next_cur.mode = cfg_wdata & MODE_MASK;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_C) begin
                next_cur.rsv_c = cfg_wdata;
            end else if (cfg_addr == ADDR_LANE01_LOW) begin
                next_cur.lane01_low = cfg_wdata;
            end else if (cfg_addr == ADDR_LANE23_LOW) begin
                next_cur.lane23_low = cfg_wdata;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_D) begin
                next_cur.rsv_d = cfg_wdata;
            end else if (cfg_addr == ADDR_SPARE_LOW) begin
                next_cur.spare_low = cfg_wdata;
            end else if (cfg_addr == ADDR_LANE_HIGH) begin
                next_cur.high_bits = cfg_wdata & HIGH_MASK;
            end
        end

        // Register reads answer one cycle later; unmapped reads give zero
        if (cfg_read) begin
            next_cur.rvalid = 1'b1;
            if (cfg_addr == ADDR_RESERVED_STATUS_A) begin
                next_cur.rdata = 16'h0000;
            end else if (cfg_addr == ADDR_RESERVED_STATUS_B) begin
                next_cur.rdata = 16'h0000;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_A) begin
                next_cur.rdata = cur.rsv_a;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_B) begin
                next_cur.rdata = cur.rsv_b;
            end else if (cfg_addr == ADDR_PATTERN_MODE) begin
                next_cur.rdata = cur.mode;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_C) begin
                next_cur.rdata = cur.rsv_c;
            end else if (cfg_addr == ADDR_LANE01_LOW) begin
                next_cur.rdata = cur.lane01_low;
            end else if (cfg_addr == ADDR_LANE23_LOW) begin
                next_cur.rdata = cur.lane23_low;
            end else if (cfg_addr == ADDR_RESERVED_SETTING_D) begin
                next_cur.rdata = cur.rsv_d;
            end else if (cfg_addr == ADDR_SPARE_LOW) begin
                next_cur.rdata = cur.spare_low;
            end else if (cfg_addr == ADDR_LANE_HIGH) begin
                next_cur.rdata = cur.high_bits;
            end else begin
                next_cur.rdata = 16'h0000;
            end
        end

        // Ramp values reload while the ramp is idle or at a frame start when framed,
        // so a framed ramp restarts at the programmed value on the word after a frame start
        for (int i = 0; i < LANES; i++) begin
            if (!(insert_en && ramp_sel) ||
                (framed && in_frame_start)) begin
                next_cur.ramp[i*WORD_W +: WORD_W] =
                    clip(lane_value(cur.lane01_low, cur.lane23_low,
                                    cur.high_bits, i), narrow_mode);
            end else if (word_step) begin
                next_cur.ramp[i*WORD_W +: WORD_W] =
                    clip(cur.ramp[i*WORD_W +: WORD_W] + 10'h001,
                         narrow_mode);
            end
        end

        // Output words; the pseudo-random source wins over the pattern
        for (int i = 0; i < LANES; i++) begin
            if (prbs_en) begin
                next_cur.odata[i*WORD_W +: WORD_W] =
                    clip(prbs_link.state[i +: WORD_W], narrow_mode);
            end else if (insert_en && ramp_sel) begin
                // Clip again: the ramp was stepped under the old width
                next_cur.odata[i*WORD_W +: WORD_W] =
                    clip(cur.ramp[i*WORD_W +: WORD_W], narrow_mode);
            end else if (insert_en) begin
                next_cur.odata[i*WORD_W +: WORD_W] =
                    clip(lane_value(cur.lane01_low, cur.lane23_low,
                                    cur.high_bits, i), narrow_mode);
            end else begin
                next_cur.odata[i*WORD_W +: WORD_W] =
                    in_data[i*WORD_W +: WORD_W];
            end
        end
        // Framing: unframed test data is valid every cycle with no syncs
        if (any_test && !framed) begin
            next_cur.ovalid = 1'b1;
            next_cur.ofs    = 1'b0;
            next_cur.ols    = 1'b0;
        end else begin
            next_cur.ovalid = in_valid;
            next_cur.ofs    = in_frame_start;
            next_cur.ols    = in_line_start;
        end
    end

    // State register with synchronous reset from the synchronised copy
    always_ff @(posedge clock) begin
        if (rst) begin
            cur            <= '0;
            cur.rsv_a      <= RST_RESERVED_SETTING_A;
            cur.rsv_b      <= RST_RESERVED_SETTING_B;
            cur.mode       <= RST_PATTERN_MODE;
            cur.rsv_c      <= RST_RESERVED_SETTING_C;
            cur.lane01_low <= RST_LANE01_LOW;
            cur.lane23_low <= RST_LANE23_LOW;
            cur.rsv_d      <= RST_RESERVED_SETTING_D;
            cur.spare_low  <= RST_SPARE_LOW;
            cur.high_bits  <= RST_LANE_HIGH;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign cfg_rdata       = cur.rdata;
    assign cfg_rvalid      = cur.rvalid;
    assign out_data        = cur.odata;
    assign out_valid       = cur.ovalid;
    assign out_frame_start = cur.ofs;
    assign out_line_start  = cur.ols;

endmodule

`default_nettype wire

// ---- dv/tpi_host_rx.sv ----
// Receiver model at the far end of the inserter's output datapaths.
// Assumes the inserter's clock; counts the words of the current frame.
`default_nettype none

module tpi_host_rx (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Stream from the inserter
    input  wire logic        valid,
    input  wire logic        frame_start,
    // Words taken since the last frame start
    output logic [15:0]      words_in_frame
);
    timeunit 1ns;
    timeprecision 1ns;

    // A frame start restarts the count, its own word included, so the
    // bench can see framing and word counts agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            words_in_frame <= 16'h0000;
        end else if (frame_start) begin
            words_in_frame <= {15'h0000, valid};
        end else if (valid) begin
            words_in_frame <= words_in_frame + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// ---- dv/tpi_inserter_monitor.sv ----
// Checker for the test pattern inserter, bound to its top module.
// Assumes mode changes arrive only through the configuration port.
`default_nettype none

module tpi_inserter_monitor
    import tpi_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // Configuration port
    input wire logic [8:0]  cfg_addr,
    input wire logic [15:0] cfg_wdata,
    input wire logic        cfg_write,
    input wire logic        cfg_read,
    input wire logic        cfg_rvalid,
    // Streams in and out
    input wire logic [39:0] in_data,
    input wire logic        in_valid,
    input wire logic        in_frame_start,
    input wire logic        in_line_start,
    input wire logic        narrow_mode,
    input wire logic [39:0] out_data,
    input wire logic        out_valid,
    input wire logic        out_frame_start,
    input wire logic        out_line_start
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mode;       // Shadow of the four mode bits
    logic       test_on;    // Pattern or generator replaces pixels
    logic       unframed;   // Test data sent without framing
    logic       const_on;   // Fixed pattern, nothing being written
    logic       ramp_on;    // Unframed wide incrementing pattern
    logic       prbs_run;   // Unframed wide generator output

    // Shadow follows writes the same cycle the design stores them
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode <= 4'h0;
        end else if (cfg_write && cfg_addr == ADDR_PATTERN_MODE) begin
            mode <= cfg_wdata[3:0];
        end
    end

    // Mode decodes; generator outranks the pattern
    assign test_on  = mode[0] | mode[2];
    assign unframed = test_on & ~mode[3];
    assign const_on = mode[0] & ~mode[1] & ~mode[2] & ~cfg_write
                      & ~narrow_mode;
    assign ramp_on  = mode[0] & mode[1] & ~mode[2] & ~mode[3] & ~narrow_mode;
    assign prbs_run = mode[2] & ~mode[3] & ~narrow_mode;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // Two cycles in a mode, so both compared words come from it
    sequence const_held; const_on ##1 const_on; endsequence
    sequence ramp_held;  ramp_on ##1 ramp_on;   endsequence
    sequence prbs_held;  prbs_run ##1 prbs_run; endsequence

    read_answer_a: assert property (cfg_rvalid == $past(cfg_read))
        else $error("read answer not one cycle after its strobe");
    pixel_pass_a: assert property ($past(!test_on && !narrow_mode) |->
        out_data == $past(in_data) && out_valid == $past(in_valid))
        else $error("pixels not passed through when test is off");
    unframed_stream_a: assert property ($past(unframed) |->
        out_valid && !out_frame_start && !out_line_start)
        else $error("unframed test data is not a continuous stream");
    framed_sync_a: assert property ($past(test_on && mode[3]) |->
        out_valid == $past(in_valid) && out_frame_start ==
        $past(in_frame_start) && out_line_start == $past(in_line_start))
        else $error("framed test data lost the sync structure");
    const_hold_a: assert property (const_held |=> $stable(out_data))
        else $error("fixed pattern changed between words");
    ramp_step_a: assert property (ramp_held |=>
        out_data[9:0] == $past(out_data[9:0]) + 10'h001)
        else $error("incrementing pattern did not step by one");
    prbs_shift_a: assert property (prbs_held |=>
        out_data[9:1] == $past(out_data[8:0]))
        else $error("generator did not shift once per word");
    prbs_lanes_a: assert property ($past(mode[2] && !narrow_mode) |->
        out_data[18:10] == out_data[9:1])
        else $error("generator lanes are not offset by one bit");
    narrow_mask_a: assert property ($past(test_on && narrow_mode) |->
        (out_data & 40'hc0300c0300) == 40'h0000000000)
        else $error("narrow words carry upper bits");
endmodule

bind tpi_inserter tpi_inserter_monitor i_tpi_inserter_monitor (
    .clock(clock), .resetn(resetn), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_rvalid(cfg_rvalid), .in_data(in_data), .in_valid(in_valid),
    .in_frame_start(in_frame_start), .in_line_start(in_line_start),
    .narrow_mode(narrow_mode), .out_data(out_data), .out_valid(out_valid),
    .out_frame_start(out_frame_start), .out_line_start(out_line_start));

`default_nettype wire

// ---- dv/tpi_inserter_tb_top.sv ----
// Testbench for the test pattern inserter: register and stream tests.
// Assumes the bound checker and the tpi_host_rx receiver model.
`default_nettype none

`define CHK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("mismatch at %0t: got %h expected %h", $time, g, e); \
        end \
    end

module tpi_inserter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tpi_pkg::*;
    logic        clock, resetn;              // Clock, reset active low
    logic [8:0]  cfg_addr;                   // Register address
    logic [15:0] cfg_wdata, cfg_rdata;       // Register data
    logic        cfg_write, cfg_read, cfg_rvalid;
    logic [39:0] in_data, out_data;          // Four packed lanes
    logic        in_valid, in_frame_start, in_line_start, narrow_mode;
    logic        out_valid, out_frame_start, out_line_start;
    logic [15:0] words_in_frame;             // Receiver's count
    int          bad_count, compares;        // Totals
    logic [39:0] base;                       // Programmed lane values
    logic [14:0] lfsr;                       // Expected generator state

    tpi_inserter i_tpi_inserter (.clock(clock), .resetn(resetn),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write),
        .cfg_read(cfg_read), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .in_data(in_data), .in_valid(in_valid),
        .in_frame_start(in_frame_start), .in_line_start(in_line_start),
        .narrow_mode(narrow_mode), .out_data(out_data),
        .out_valid(out_valid), .out_frame_start(out_frame_start),
        .out_line_start(out_line_start));
    tpi_host_rx i_tpi_host_rx (.clock(clock), .resetn(resetn),
        .valid(out_valid), .frame_start(out_frame_start),
        .words_in_frame(words_in_frame));

    // Each lane of b advanced by k, wrapping at ten bits
    function automatic logic [39:0] ramp(input logic [39:0] b, input int k);
        logic [39:0] r;
        for (int i = 0; i < 4; i++) r[i*10 +: 10] = b[i*10 +: 10] + 10'(k);
        return r;
    endfunction

    // Lane i shows generator bits i+9 down to i
    function automatic logic [39:0] prbs_lanes(input logic [14:0] s);
        return {s[12:3], s[11:2], s[10:1], s[9:0]};
    endfunction

    // One register write; the strobe lasts a single cycle
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clock);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_write <= 1'b1;
        @(posedge clock);
        cfg_write <= 1'b0;
    endtask

    // One register read; the answer stands only in the next cycle
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        @(posedge clock);
        cfg_addr <= a;
        cfg_read <= 1'b1;
        @(posedge clock);
        cfg_read <= 1'b0;
        #1;
        `CHK(cfg_rvalid, 1'b1)
        `CHK(cfg_rdata, e)
    endtask

    // Drive one pixel cycle; outputs of the previous one are then settled
    task automatic cyc(input logic [39:0] d, input logic v, f, l);
        @(posedge clock);
        in_data <= d;
        in_valid <= v;
        in_frame_start <= f;
        in_line_start <= l;
        #1;
    endtask

    // Bounded wait for a known word, as start-up latency is not fixed
    task automatic wait_word(input logic [39:0] w);
        int n;
        n = 0;
        cyc('0, 1'b0, 1'b0, 1'b0);
        while (out_data !== w && n < 6) begin
            n++;
            cyc('0, 1'b0, 1'b0, 1'b0);
        end
        `CHK(out_data, w)
    endtask

    // Single place where the run ends
    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Cuts a hang short; the tests need about 70 cycles
    initial begin
        #(3000 * 100);
        bad_count++;
        end_of_test();
    end

    initial begin
        {cfg_addr, cfg_wdata, cfg_write, cfg_read} = '0;
        {in_data, in_valid, in_frame_start, in_line_start} = '0;
        narrow_mode = 1'b0;
        bad_count = 0;
        compares = 0;
        resetn = 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        rd(ADDR_RESERVED_SETTING_B, 16'hffff);
        rd(ADDR_PATTERN_MODE, 16'h0000);
        rd(ADDR_LANE01_LOW, 16'h0100);
        rd(ADDR_LANE23_LOW, 16'h0302);
        rd(ADDR_RESERVED_SETTING_D, 16'h0504);
        rd(ADDR_SPARE_LOW, 16'h0706);
        rd(ADDR_LANE_HIGH, 16'h0000);
        rd(9'h1ff, 16'h0000);
        wr(ADDR_RESERVED_STATUS_A, 16'h1234);
        rd(ADDR_RESERVED_STATUS_A, 16'h0000);
        wr(ADDR_PATTERN_MODE, 16'hfff0);
        rd(ADDR_PATTERN_MODE, 16'h0000);
        $display("register test done");
        cyc(40'h123456789a, 1'b1, 1'b1, 1'b0);
        cyc('0, 1'b0, 1'b0, 1'b1);
        `CHK({out_data, out_frame_start}, {40'h123456789a, 1'b1})
        $display("pass-through test done");
        wr(ADDR_LANE01_LOW, 16'h5aa5);
        wr(ADDR_LANE23_LOW, 16'h3c7e);
        wr(ADDR_LANE_HIGH, 16'hffe4);
        rd(ADDR_LANE_HIGH, 16'h00e4);
        rd(ADDR_LANE01_LOW, 16'h5aa5);
        base = {10'h33c, 10'h27e, 10'h15a, 10'h0a5};
        wr(ADDR_PATTERN_MODE, 16'h0001);
        cyc('0, 1'b0, 1'b1, 1'b1);
        cyc('0, 1'b0, 1'b0, 1'b0);
        `CHK(out_data, base)
        `CHK({out_valid, out_frame_start}, 2'b10)
        narrow_mode <= 1'b1;
        cyc('0, 1'b0, 1'b0, 1'b0);
        `CHK(out_data, base & ~40'hc0300c0300)
        narrow_mode <= 1'b0;
        $display("fixed pattern test done");
        wr(ADDR_LANE23_LOW, 16'hff7e);
        base[39:30] = 10'h3ff;
        wr(ADDR_PATTERN_MODE, 16'h0003);
        wait_word(base);
        for (int k = 1; k < 4; k++) begin
            cyc('0, 1'b0, 1'b0, 1'b0);
            `CHK(out_data, ramp(base, k))
        end
        wr(ADDR_PATTERN_MODE, 16'h000b);
        cyc('0, 1'b0, 1'b1, 1'b0);
        cyc('0, 1'b1, 1'b0, 1'b1);
        `CHK(out_frame_start, 1'b1)
        cyc('0, 1'b0, 1'b0, 1'b0);
        `CHK({out_valid, out_line_start, out_data}, {2'b11, base})
        cyc('0, 1'b1, 1'b0, 1'b0);
        `CHK(out_valid, 1'b0)
        cyc('0, 1'b0, 1'b0, 1'b0);
        `CHK(out_data, ramp(base, 1))
        cyc('0, 1'b0, 1'b0, 1'b0);
        `CHK(words_in_frame, 16'h0002)
        $display("incrementing pattern test done");
        wr(ADDR_PATTERN_MODE, 16'h0005);
        lfsr = PRBS_SEED;
        wait_word(prbs_lanes(lfsr));
        for (int k = 0; k < 3; k++) begin
            lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
            cyc('0, 1'b0, 1'b0, 1'b0);
            `CHK(out_data, prbs_lanes(lfsr))
        end
        $display("generator test done");
        end_of_test();
    end
endmodule

`default_nettype wire
